// ---- verif/mpp_sink_model.sv ----
// byte sink standing for the frame transmission path toward the host buffer
module mpp_sink_model (
  // clock and stall control
  input  wire logic       i_sys_clk,
  input  wire logic       i_stall,
  // byte stream from the packer
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  input  wire logic       i_last,
  output logic            o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic       got_last[$];
  logic [1:0] phase;
  initial begin
    o_ready = 1'b0;
    phase = 2'h0;
  end
  // while i_stall is set the slow host takes one byte in four, so the fifo backs up; otherwise every byte is taken
  always @(posedge i_sys_clk) begin
    if (o_ready && i_valid) begin
      got.push_back(i_data);
      got_last.push_back(i_last);
    end
    phase <= phase + 2'h1;
    o_ready <= !i_stall || (phase == 2'h3);
  end
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the mono pixel packer
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_sys_clk, i_rst, i_pix_valid, i_pix_first, i_pix_last, i_stall;
  logic [1:0]  i_layout;
  logic [11:0] i_pix_data;
  logic        o_pix_ready, o_byte_valid, o_byte_last, byte_ready;
  logic [7:0]  o_byte_data, o_leader_code;
  int          num_errors, n_checks, cycles;
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  mpp_packer #(.DEPTH(mpp_pkg::FIFO_DEPTH)) uut (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_layout(i_layout), .i_pix_valid(i_pix_valid),
    .i_pix_data(i_pix_data), .i_pix_first(i_pix_first), .i_pix_last(i_pix_last),
    .o_pix_ready(o_pix_ready), .o_byte_valid(o_byte_valid), .o_byte_data(o_byte_data),
    .o_byte_last(o_byte_last), .i_byte_ready(byte_ready), .o_leader_code(o_leader_code));
  mpp_sink_model sink (
    .i_sys_clk(i_sys_clk), .i_stall(i_stall), .i_valid(o_byte_valid),
    .i_data(o_byte_data), .i_last(o_byte_last), .o_ready(byte_ready));
  ////////////////////////////////////////////////////////////////
  task test_done;
    $display("checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // hang guard, well above the few hundred cycles the frames need
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      test_done();
    end
  end
  task check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task check_bit(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s: expected %b, seen %b", name, exp, got);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  // entered at a falling edge; valid stays up so the next call just swaps data
  task send_pix(input logic [11:0] d, input logic f, input logic l);
    int n;
    i_pix_valid = 1'b1;
    i_pix_data = d;
    i_pix_first = f;
    i_pix_last = l;
    n = 0;
    while (o_pix_ready !== 1'b1 && n < 200) begin
      @(negedge i_sys_clk);
      n++;
    end
    @(negedge i_sys_clk);
  endtask
  task run_frame(input logic [1:0] lay, input logic [11:0] px[$], input logic [7:0] lead);
    logic [7:0] exp[$];
    int         n;
    exp = {};
    for (int i = 0; i < px.size(); i++) begin
      if (lay == mpp_pkg::LAYOUT_WIDE) begin
        exp.push_back(px[i][7:0]);
        exp.push_back({4'h0, px[i][11:8]});
      end else if (lay == mpp_pkg::LAYOUT_PACKED && i % 2 == 1) begin
        exp.push_back({px[i][3:0], px[i-1][3:0]});
        exp.push_back(px[i][11:4]);
      end else begin
        exp.push_back(px[i][11:4]);
      end
      if (lay == mpp_pkg::LAYOUT_PACKED && i % 2 == 0 && i == px.size() - 1) begin
        exp.push_back({4'h0, px[i][3:0]});
        exp.push_back(8'h00);
      end
    end
    sink.got.delete();
    sink.got_last.delete();
    @(negedge i_sys_clk);
    i_layout = lay;
    for (int i = 0; i < px.size(); i++) send_pix(px[i], i == 0, i == px.size() - 1);
    i_pix_valid = 1'b0;
    i_pix_first = 1'b0;
    i_pix_last = 1'b0;
    n = 0;
    while (sink.got.size() < exp.size() && n < 400) begin
      @(negedge i_sys_clk);
      n++;
    end
    repeat (6) @(negedge i_sys_clk);
    check_byte("byte count", 8'(exp.size()), 8'(sink.got.size()));
    for (int i = 0; i < exp.size(); i++) begin
      check_byte("frame byte", exp[i], sink.got[i]);
      check_bit("last flag", i == exp.size() - 1, sink.got_last[i]);
    end
    check_byte("leader code", lead, o_leader_code);
  endtask
  ////////////////////////////////////////////////////////////////
  // reset held n cycles, then idle outputs checked at release
  task test_reset(input int n);
    i_rst = 1'b1;
    repeat (n) @(negedge i_sys_clk);
    i_rst = 1'b0;
    check_byte("leader after reset", mpp_pkg::LEADER_RESET, o_leader_code);
    check_bit("ready after reset", 1'b1, o_pix_ready);
    check_bit("valid after reset", 1'b0, o_byte_valid);
    check_bit("last after reset", 1'b0, o_byte_last);
    check_byte("data after reset", 8'h00, o_byte_data);
  endtask
  ////////////////////////////////////////////////////////////////
  task test_mono8;
    run_frame(mpp_pkg::LAYOUT_MONO8, {12'hfff, 12'h000, 12'ha5c, 12'h0f0},
              mpp_pkg::LEADER_MONO8);
  endtask
  task test_wide;
    run_frame(mpp_pkg::LAYOUT_WIDE, {12'hfff, 12'h000, 12'h123},
              mpp_pkg::LEADER_REDUCED);
  endtask
  task test_packed_stall;
    i_stall = 1'b1;
    run_frame(mpp_pkg::LAYOUT_PACKED, {12'h123, 12'h456, 12'hfff, 12'h000, 12'h789, 12'habc},
              mpp_pkg::LEADER_PACKED);
    i_stall = 1'b0;
  endtask
  task test_packed_odd;
    run_frame(mpp_pkg::LAYOUT_PACKED, {12'habc, 12'hdef, 12'h135},
              mpp_pkg::LEADER_PACKED);
  endtask
  task test_code3;
    run_frame(2'h3, {12'h7e1, 12'h800}, mpp_pkg::LEADER_MONO8);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    num_errors = 0;
    n_checks = 0;
    cycles = 0;
    i_rst = 1'b1;
    i_layout = 2'h0;
    i_pix_valid = 1'b0;
    i_pix_data = 12'h000;
    i_pix_first = 1'b0;
    i_pix_last = 1'b0;
    i_stall = 1'b0;
    test_reset(12);
    test_mono8();
    test_wide();
    test_packed_stall();
    test_packed_odd();
    test_reset(2);
    test_code3();
    test_mono8();
    test_done();
  end
endmodule

// ---- verilog/mpp_byte_fifo.sv ----
// byte fifo with memory and registered read stage
module mpp_byte_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic           i_sys_clk,
  input  wire logic           i_rst,
  // both sides
  mpp_fifo_if.fifo_side       fif
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic          out_valid_ff;
  logic [W-1:0]  out_data_ff;
  logic          push;
  logic          pop;

  assign fif.wr_ready = (count_ff != FULL_CNT);
  assign push         = fif.wr_valid && fif.wr_ready;
  // refill the output stage whenever it empties or is taken
  assign pop          = (count_ff != '0) && (!out_valid_ff || fif.rd_ready);
  assign fif.rd_valid = out_valid_ff;
  assign fif.rd_data  = out_data_ff;

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= fif.wr_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= count_ff + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else if (pop) begin
      out_valid_ff <= 1'b1;
      out_data_ff  <= mem[rd_ptr_ff];
    end else if (fif.rd_ready) begin
      out_valid_ff <= 1'b0;
    end
  end
endmodule

// ---- verilog/mpp_fifo_if.sv ----
// byte fifo handshake between packer logic and its fifo
interface mpp_fifo_if #(parameter int W = 9);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  modport fifo_side (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport user_side (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface

// ---- verilog/mpp_packer.sv ----
// mono pixel packer: 12-bit samples to frame byte stream
module mpp_packer #(
  parameter int DEPTH = mpp_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                     i_sys_clk,
  input  wire logic                     i_rst,
  // configuration
  input  wire logic [1:0]               i_layout,
  // pixel source
  input  wire logic                     i_pix_valid,
  input  wire logic [mpp_pkg::PIX_W-1:0] i_pix_data,
  input  wire logic                     i_pix_first,
  input  wire logic                     i_pix_last,
  output logic                          o_pix_ready,
  // byte stream toward frame transmission
  output logic                          o_byte_valid,
  output logic [mpp_pkg::BYTE_W-1:0]    o_byte_data,
  output logic                          o_byte_last,
  input  wire logic                     i_byte_ready,
  // leader format code of the current frame
  output logic [7:0]                    o_leader_code
);
  mpp_fifo_if #(.W(mpp_pkg::FIFO_W)) fif ();

  mpp_pkg::mpp_state_t state_ff;
  logic [1:0]          layout_ff;
  logic [1:0]          layout_now;
  logic                odd_ff;
  logic [3:0]          even_lo_ff;
  logic [7:0]          byte0_ff;
  logic [7:0]          byte1_ff;
  logic [7:0]          byte2_ff;
  logic [1:0]          nbytes_ff;
  logic [1:0]          idx_ff;
  logic                last_ff;
  logic [7:0]          leader_ff;
  logic                take;
  logic                wr_done;
  logic                final_byte;
  logic [7:0]          cur_byte;

  // reserved code falls back to the one-byte layout
  // layout select, latched at frame start
  assign layout_now = i_pix_first ? i_layout : layout_ff;
  assign take       = (state_ff == mpp_pkg::ST_TAKE) && i_pix_valid;
  assign final_byte = (idx_ff == nbytes_ff - 2'h1);
  assign wr_done    = fif.wr_valid && fif.wr_ready;

  always_comb begin
    case (idx_ff)
      2'h0:    cur_byte = byte0_ff;
      2'h1:    cur_byte = byte1_ff;
      default: cur_byte = byte2_ff;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // fifo write side and output side
  assign fif.wr_valid = (state_ff == mpp_pkg::ST_SEND);
  assign fif.wr_data  = {last_ff && final_byte, cur_byte};
  assign fif.rd_ready = i_byte_ready;
  assign o_byte_valid = fif.rd_valid;
  assign o_byte_data  = fif.rd_data[mpp_pkg::BYTE_W-1:0];
  assign o_byte_last  = fif.rd_data[mpp_pkg::LAST_BIT];
  // one-hot: bit 0 is the take state, so ready comes straight from the flop
  assign o_pix_ready  = state_ff[0];
  assign o_leader_code = leader_ff;

  mpp_byte_fifo #(
    .W     (mpp_pkg::FIFO_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .fif       (fif)
  );

  ////////////////////////////////////////////////////////////////
  // state: take one pixel, then push its bytes one per cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_ff <= mpp_pkg::ST_TAKE;
      idx_ff   <= mpp_pkg::IDX_RESET;
    end else begin
      case (state_ff)
        mpp_pkg::ST_TAKE: begin
          idx_ff <= mpp_pkg::IDX_RESET;
          if (take) begin
            state_ff <= mpp_pkg::ST_SEND;
          end
        end
        mpp_pkg::ST_SEND: begin
          if (wr_done) begin
            idx_ff <= idx_ff + 2'h1;
            if (final_byte) begin
              state_ff <= mpp_pkg::ST_TAKE;
            end
          end
        end
        default: begin
          state_ff <= mpp_pkg::ST_TAKE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // layout, leader code and packed phase tracking
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      layout_ff <= mpp_pkg::LAYOUT_MONO8;
      leader_ff <= mpp_pkg::LEADER_RESET;
    end else if (take && i_pix_first) begin
      layout_ff <= i_layout;
      // reduced-depth code for the two-byte layout
      case (i_layout)
        mpp_pkg::LAYOUT_WIDE:   leader_ff <= mpp_pkg::LEADER_REDUCED;
        mpp_pkg::LAYOUT_PACKED: leader_ff <= mpp_pkg::LEADER_PACKED;
        default:                leader_ff <= mpp_pkg::LEADER_MONO8;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      odd_ff     <= 1'b0;
      even_lo_ff <= mpp_pkg::PAD_NIBBLE;
    end else if (take && layout_now == mpp_pkg::LAYOUT_PACKED) begin
      // a new frame always restarts on an even pixel
      odd_ff <= i_pix_last ? 1'b0 : ((i_pix_first ? 1'b0 : odd_ff) ^ 1'b1);
      if (i_pix_first || !odd_ff) begin
        even_lo_ff <= i_pix_data[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // byte formation per layout
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      byte0_ff  <= mpp_pkg::PAD_BYTE;
      byte1_ff  <= mpp_pkg::PAD_BYTE;
      byte2_ff  <= mpp_pkg::PAD_BYTE;
      nbytes_ff <= mpp_pkg::NBYTES_ONE;
      last_ff   <= 1'b0;
    end else if (take) begin
      last_ff  <= i_pix_last;
      byte1_ff <= mpp_pkg::PAD_BYTE;
      byte2_ff <= mpp_pkg::PAD_BYTE;
      case (layout_now)
        mpp_pkg::LAYOUT_WIDE: begin
          // low byte first, high byte second
          byte0_ff  <= i_pix_data[7:0];
          byte1_ff  <= {mpp_pkg::PAD_NIBBLE, i_pix_data[11:8]};
          nbytes_ff <= mpp_pkg::NBYTES_TWO;
        end
        mpp_pkg::LAYOUT_PACKED: begin
          if (odd_ff && !i_pix_first) begin
            // odd pixel: shared nibble byte then high bits
            byte0_ff  <= {i_pix_data[3:0], even_lo_ff};
            byte1_ff  <= i_pix_data[11:4];
            nbytes_ff <= mpp_pkg::NBYTES_TWO;
          end else if (i_pix_last) begin
            // odd one out: pad the missing partner with zeros
            byte0_ff  <= i_pix_data[11:4];
            byte1_ff  <= {mpp_pkg::PAD_NIBBLE, i_pix_data[3:0]};
            nbytes_ff <= mpp_pkg::NBYTES_THREE;
          end else begin
            // even pixel sends only its high bits now
            byte0_ff  <= i_pix_data[11:4];
            nbytes_ff <= mpp_pkg::NBYTES_ONE;
          end
        end
        default: begin
          // level kept as the upper eight bits
          byte0_ff  <= i_pix_data[11:mpp_pkg::MSB_LO];
          nbytes_ff <= mpp_pkg::NBYTES_ONE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  // one-byte value
  mono_byte_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && layout_now == mpp_pkg::LAYOUT_MONO8
    |=> byte0_ff == $past(i_pix_data[11:4]) && nbytes_ff == 2'h1)
    else $error("one-byte value wrong");
  mono_count_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && layout_now == mpp_pkg::LAYOUT_MONO8
    |=> fif.wr_valid && final_byte)
    else $error("one-byte count wrong");
  wide_count_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && layout_now == mpp_pkg::LAYOUT_WIDE |=> nbytes_ff == 2'h2)
    else $error("two-byte count wrong");
  wide_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    wr_done && layout_ff == mpp_pkg::LAYOUT_WIDE && idx_ff == 2'h1
    |-> fif.wr_data[7:4] == 4'h0)
    else $error("high nibble not zero");
  wide_order_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && layout_now == mpp_pkg::LAYOUT_WIDE
    |=> byte0_ff == $past(i_pix_data[7:0]) && byte1_ff[3:0] == $past(i_pix_data[11:8]))
    else $error("two-byte order wrong");
  wide_range_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    state_ff == mpp_pkg::ST_SEND && layout_ff == mpp_pkg::LAYOUT_WIDE
    |-> {byte1_ff, byte0_ff} <= 16'h0FFF)
    else $error("two-byte word above range");
  leader_code_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && i_pix_first && i_layout == mpp_pkg::LAYOUT_WIDE
    |=> o_leader_code == mpp_pkg::LEADER_REDUCED)
    else $error("leader code not reduced");
  pack_pair_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && layout_now == mpp_pkg::LAYOUT_PACKED && odd_ff && !i_pix_first
    |=> byte0_ff == {$past(i_pix_data[3:0]), $past(even_lo_ff)}
        && byte1_ff == $past(i_pix_data[11:4]))
    else $error("packed pair wrong");
  pack_even_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && layout_now == mpp_pkg::LAYOUT_PACKED && (!odd_ff || i_pix_first) && !i_pix_last
    |=> nbytes_ff == 2'h1 ##1 odd_ff)
    else $error("packed even count wrong");
  layout_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    take && !i_pix_first |=> $stable(layout_ff))
    else $error("layout changed in frame");

  mono_seen_c:   cover property (@(posedge i_sys_clk) take && layout_now == 2'h0);
  wide_seen_c:   cover property (@(posedge i_sys_clk) take && layout_now == 2'h1);
  pack_pair_c:   cover property (@(posedge i_sys_clk) take && layout_now == 2'h2 && odd_ff);
  fifo_full_c:   cover property (@(posedge i_sys_clk) fif.wr_valid && !fif.wr_ready);
endmodule

// ---- verilog/mpp_pkg.sv ----
// constants shared by the mono pixel packer and its byte fifo
package mpp_pkg;
  ////////////////////////////////////////////////////////////////
  // layout select codes
  localparam logic [1:0] LAYOUT_MONO8  = 2'h0;
  localparam logic [1:0] LAYOUT_WIDE   = 2'h1;
  localparam logic [1:0] LAYOUT_PACKED = 2'h2;
  ////////////////////////////////////////////////////////////////
  // leader format codes, values arbitrary
  localparam logic [7:0] LEADER_MONO8   = 8'h01;
  localparam logic [7:0] LEADER_REDUCED = 8'h02;
  localparam logic [7:0] LEADER_PACKED  = 8'h03;
  localparam logic [7:0] LEADER_RESET   = 8'h00;
  ////////////////////////////////////////////////////////////////
  // widths, field positions and reset values
  localparam int         PIX_W          = 12;
  localparam int         BYTE_W         = 8;
  localparam int         FIFO_W         = 9;
  localparam int         FIFO_DEPTH     = 8;
  localparam int         LAST_BIT       = 8;
  localparam int         MSB_LO         = 4;
  localparam logic [3:0] PAD_NIBBLE     = 4'h0;
  localparam logic [7:0] PAD_BYTE       = 8'h00;
  localparam logic [1:0] NBYTES_ONE     = 2'h1;
  localparam logic [1:0] NBYTES_TWO     = 2'h2;
  localparam logic [1:0] NBYTES_THREE   = 2'h3;
  localparam logic [1:0] IDX_RESET      = 2'h0;
  ////////////////////////////////////////////////////////////////
  // packer states, one-hot
  typedef enum logic [1:0] {
    ST_TAKE = 2'b01,
    ST_SEND = 2'b10
  } mpp_state_t;
endpackage
